//--- core/asp_pkg.sv
// Shared constants for the angle sensor serial link and its controller.
package asp_pkg;
  // ****************************************
  // Timing
  // ****************************************
  localparam int CLK_PERIOD_PS = 25000;
  localparam int T_HALF_NS = 200;
  localparam int T_FAST_HALF_NS = 100;
  localparam int T_LEAD_NS = 250;
  localparam int HALF_CYC = (T_HALF_NS * 1000 + CLK_PERIOD_PS - 1)
                            / CLK_PERIOD_PS;
  localparam int FAST_HALF_CYC = (T_FAST_HALF_NS * 1000 + CLK_PERIOD_PS - 1)
                                 / CLK_PERIOD_PS;
  localparam int LEAD_CYC = (T_LEAD_NS * 1000 + CLK_PERIOD_PS - 1)
                            / CLK_PERIOD_PS;
  // ****************************************
  // Frame and device registers
  // ****************************************
  localparam int ANGLE_W = 14;
  localparam int FRAME_BITS = 16;
  localparam int BURST_BITS = 24;
  localparam logic [6:0] IDX_ANGLE_HI = 7'h03;
  localparam logic [6:0] IDX_ANGLE_LO = 7'h04;
  localparam int LOSS_BIT = 1;
  localparam int SY_SCLK = 0;
  localparam int SY_CS = 1;
  localparam int SY_DAT = 2;
  // ****************************************
  // Controller registers on APB
  // ****************************************
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_RXDATA = 8'h08;
  localparam logic [7:0] OFS_IRQ_STAT = 8'h0C;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h10;
  localparam int CTRL_GO = 0;
  localparam int CTRL_READ = 1;
  localparam int CTRL_BURST = 2;
  localparam int CTRL_3W = 3;
  localparam int CTRL_FAST = 4;
  localparam int CTRL_IDX_LSB = 8;
  localparam int CTRL_WDATA_LSB = 16;
  localparam int STATUS_BUSY = 0;
  localparam int IRQ_DONE = 0;
  localparam logic [31:0] REG_RESET = 32'h0000_0000;
endpackage

//--- core/asp_spi_if.sv
// Serial link between the angle sensor port and its master.
`timescale 1ns/1ps
interface asp_spi_if;
  logic sclk;
  logic chip_select_n;
  logic hostDat;
  logic hostDatOeN;
  logic devSdat;
  logic devSdatOeN;
  logic devMiso;
  logic devMisoOeN;
  logic bidirectional_serial_data;
  logic miso;
  // Undriven lines float high through a pull-up.
  assign bidirectional_serial_data = !hostDatOeN ? hostDat : (!devSdatOeN ? devSdat : 1'b1);
  assign miso = !devMisoOeN ? devMiso : 1'b1;
  modport device (
    input sclk, chip_select_n, bidirectional_serial_data,
    output devSdat, devSdatOeN, devMiso, devMisoOeN
  );
  modport host (
    output sclk, chip_select_n, hostDat, hostDatOeN,
    input bidirectional_serial_data, miso
  );
endinterface

//--- core/asp_device.sv
// Sensor end of the serial link: frame decode, angle readout, writes.
`timescale 1ns/1ps
module asp_device import asp_pkg::*; (
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Serial link
  asp_spi_if.device spi,
  // Sensor values and strap
  input wire logic [ANGLE_W-1:0] angle,
  input wire logic fieldLoss,
  input wire logic threeWireSelect,
  // Bytes written by the master
  output logic writeStrobe,
  output logic [6:0] writeIndex,
  output logic [7:0] writeData
);

  typedef enum {DEV_IDLE, DEV_ACTIVE} asp_dev_state_t;

  // ****************************************
  // Register readout
  // ****************************************
  function automatic logic [7:0] regRead(input logic [6:0] idx,
                                         input logic [ANGLE_W-1:0] ang,
                                         input logic loss);
    logic [7:0] v;
    v = 8'h00;
    case (idx)
      IDX_ANGLE_HI: v = ang[13:6];
      IDX_ANGLE_LO: begin
        v = {ang[5:0], 2'b00};
        v[LOSS_BIT] = loss;
      end
      default: v = 8'h00;
    endcase
    return v;
  endfunction

  // ****************************************
  // Link input synchronisers
  // ****************************************
  logic [2:0] rawIn;
  logic [2:0] s1_q, s1_d, s2_q, s2_d, s3_q, s3_d, filt_q, filt_d;
  logic sclkRise, sclkFall, csFall, csRise, bitIn;

  assign rawIn = {spi.bidirectional_serial_data, spi.chip_select_n, spi.sclk};

  always_comb begin
    s1_d = rawIn;
    s2_d = s1_q;
    s3_d = s2_q;
    for (int i = 0; i < 3; i++) begin
      filt_d[i] = (s2_q[i] == s3_q[i]) ? s3_q[i] : filt_q[i];
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      s1_q <= 3'h7;
      s2_q <= 3'h7;
      s3_q <= 3'h7;
      filt_q <= 3'h7;
    end else begin
      s1_q <= s1_d;
      s2_q <= s2_d;
      s3_q <= s3_d;
      filt_q <= filt_d;
    end
  end

  // Clock edges are seen only while selected; stray edges are ignored.
  assign sclkRise = !filt_q[SY_SCLK] && filt_d[SY_SCLK];
  assign sclkFall = filt_q[SY_SCLK] && !filt_d[SY_SCLK];
  assign csFall = filt_q[SY_CS] && !filt_d[SY_CS];
  assign csRise = !filt_q[SY_CS] && filt_d[SY_CS];
  assign bitIn = filt_d[SY_DAT];

  // ****************************************
  // Frame engine
  // ****************************************
  asp_dev_state_t st_q, st_d;
  logic [3:0] cnt_q, cnt_d;
  logic [7:0] shift_q, shift_d, shiftNew;
  logic [7:0] tx_q, tx_d;
  logic [6:0] idx_q, idx_d, idxNext;
  logic isRead_q, isRead_d;
  logic threeWire_q, threeWire_d;
  logic [ANGLE_W-1:0] snap_q, snap_d;
  logic loss_q, loss_d;
  logic out_q, out_d;
  logic sdatOeN_q, sdatOeN_d, misoOeN_q, misoOeN_d;
  logic wrStb_q, wrStb_d;
  logic [6:0] wrIdx_q, wrIdx_d;
  logic [7:0] wrData_q, wrData_d;

  assign shiftNew = {shift_q[6:0], bitIn};
  assign idxNext = idx_q + 7'h01;

  always_comb begin
    st_d = st_q;
    cnt_d = cnt_q;
    shift_d = shift_q;
    tx_d = tx_q;
    idx_d = idx_q;
    isRead_d = isRead_q;
    threeWire_d = threeWire_q;
    snap_d = snap_q;
    loss_d = loss_q;
    out_d = out_q;
    sdatOeN_d = sdatOeN_q;
    misoOeN_d = misoOeN_q;
    wrStb_d = 1'b0;
    wrIdx_d = wrIdx_q;
    wrData_d = wrData_q;
    case (st_q)
      DEV_IDLE: begin
        if (csFall) begin
          st_d = DEV_ACTIVE;
          cnt_d = 4'h0;
          isRead_d = 1'b0;
          // Freezing the angle keeps both bytes of one reading coherent.
          snap_d = angle;
          loss_d = fieldLoss;
          threeWire_d = threeWireSelect;
        end
      end
      DEV_ACTIVE: begin
        if (csRise) begin
          st_d = DEV_IDLE;
          sdatOeN_d = 1'b1;
          misoOeN_d = 1'b1;
          out_d = 1'b1;
        end else if (sclkRise) begin
          shift_d = shiftNew;
          cnt_d = (cnt_q == 4'hF) ? 4'h8 : cnt_q + 4'h1;
          if (cnt_q == 4'h7) begin
            isRead_d = shiftNew[7];
            idx_d = shiftNew[6:0];
            if (shiftNew[7]) begin
              tx_d = regRead(shiftNew[6:0], snap_q, loss_q);
            end
          end else if (cnt_q == 4'hF) begin
            idx_d = idxNext;
            if (isRead_q) begin
              tx_d = regRead(idxNext, snap_q, loss_q);
            end else begin
              wrStb_d = 1'b1;
              wrIdx_d = idx_q;
              wrData_d = shiftNew;
            end
          end
        end else if (sclkFall && cnt_q[3] && isRead_q) begin
          // Data bits leave MSB first, one per falling edge.
          out_d = tx_q[7];
          tx_d = {tx_q[6:0], 1'b0};
          sdatOeN_d = !threeWire_q;
          misoOeN_d = threeWire_q;
        end
      end
      default: st_d = DEV_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      st_q <= DEV_IDLE;
      cnt_q <= 4'h0;
      shift_q <= 8'h00;
      tx_q <= 8'h00;
      idx_q <= 7'h00;
      isRead_q <= 1'b0;
      threeWire_q <= 1'b0;
      snap_q <= '0;
      loss_q <= 1'b0;
      out_q <= 1'b1;
      sdatOeN_q <= 1'b1;
      misoOeN_q <= 1'b1;
      wrStb_q <= 1'b0;
      wrIdx_q <= 7'h00;
      wrData_q <= 8'h00;
    end else begin
      st_q <= st_d;
      cnt_q <= cnt_d;
      shift_q <= shift_d;
      tx_q <= tx_d;
      idx_q <= idx_d;
      isRead_q <= isRead_d;
      threeWire_q <= threeWire_d;
      snap_q <= snap_d;
      loss_q <= loss_d;
      out_q <= out_d;
      sdatOeN_q <= sdatOeN_d;
      misoOeN_q <= misoOeN_d;
      wrStb_q <= wrStb_d;
      wrIdx_q <= wrIdx_d;
      wrData_q <= wrData_d;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  // The three-stage sampler costs about four clocks per edge, so a
  // 100 ns clock phase leaves no room; the fast period needs a faster
  // core clock than 40 MHz.
  assign spi.devSdat = out_q;
  assign spi.devSdatOeN = sdatOeN_q;
  assign spi.devMiso = out_q;
  assign spi.devMisoOeN = misoOeN_q;
  assign writeStrobe = wrStb_q;
  assign writeIndex = wrIdx_q;
  assign writeData = wrData_q;

endmodule // asp_device

//--- core/asp_host.sv
// Master end of the serial link, driven by software over APB.
//
// Decided for this implementation: the APB interface to the registers.
`timescale 1ns/1ps
module asp_host import asp_pkg::*; (
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Interrupt
  output logic irq,
  // Serial link
  asp_spi_if.host spi
);

  typedef enum {H_IDLE, H_LEAD, H_LOW, H_HIGH, H_TRAIL} asp_host_state_t;

  // ****************************************
  // Returned data synchronisers
  // ****************************************
  logic [1:0] s1_q, s2_q, s3_q, filt_q, filt_d;
  logic rxBit;

  always_comb begin
    for (int i = 0; i < 2; i++) begin
      filt_d[i] = (s2_q[i] == s3_q[i]) ? s3_q[i] : filt_q[i];
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      s1_q <= 2'h3;
      s2_q <= 2'h3;
      s3_q <= 2'h3;
      filt_q <= 2'h3;
    end else begin
      s1_q <= {spi.miso, spi.bidirectional_serial_data};
      s2_q <= s1_q;
      s3_q <= s2_q;
      filt_q <= filt_d;
    end
  end

  // ****************************************
  // Control, frame engine and APB
  // ****************************************
  asp_host_state_t st_q, st_d;
  logic [4:0] tmr_q, tmr_d, bits_q, bits_d, half, lastBit;
  logic [15:0] tx_q, tx_d, rx_q, rx_d, rxData_q, rxData_d;
  logic read_q, read_d, burst_q, burst_d, tw_q, tw_d, fast_q, fast_d;
  logic [6:0] idx_q, idx_d;
  logic [7:0] wdata_q, wdata_d;
  logic sclk_q, sclk_d, csN_q, csN_d, dat_q, dat_d, oeN_q, oeN_d;
  logic stat_q, stat_d, mask_q, mask_d, irq_q, irq_d;
  logic [31:0] prdata_q, prdata_d;
  logic pslverr_q, pslverr_d, setup, wrAcc, done, mapped;

  // The reply reaches the line four clocks after a falling edge and needs
  // four more to pass the sampler, so the rising edge takes the filter's
  // next value; its registered copy would still hold the previous bit.
  assign rxBit = tw_q ? filt_d[0] : filt_d[1];
  assign half = fast_q ? 5'(FAST_HALF_CYC - 1) : 5'(HALF_CYC - 1);
  assign lastBit = burst_q ? 5'(BURST_BITS - 1) : 5'(FRAME_BITS - 1);
  assign setup = psel && !penable;
  assign wrAcc = psel && penable && pwrite;
  assign mapped = paddr == OFS_CTRL || paddr == OFS_STATUS ||
                  paddr == OFS_RXDATA || paddr == OFS_IRQ_STAT ||
                  paddr == OFS_IRQ_MASK;

  always_comb begin
    st_d = st_q;
    tmr_d = tmr_q;
    bits_d = bits_q;
    tx_d = tx_q;
    rx_d = rx_q;
    rxData_d = rxData_q;
    read_d = read_q;
    burst_d = burst_q;
    tw_d = tw_q;
    fast_d = fast_q;
    idx_d = idx_q;
    wdata_d = wdata_q;
    sclk_d = sclk_q;
    csN_d = csN_q;
    dat_d = dat_q;
    oeN_d = oeN_q;
    mask_d = mask_q;
    done = 1'b0;
    prdata_d = prdata_q;
    pslverr_d = pslverr_q;
    if (tmr_q != 5'h00) begin
      tmr_d = tmr_q - 5'h01;
    end
    case (st_q)
      H_IDLE: begin
        sclk_d = 1'b1;
        if (wrAcc && paddr == OFS_CTRL) begin
          read_d = pwdata[CTRL_READ];
          burst_d = pwdata[CTRL_BURST] && pwdata[CTRL_READ];
          tw_d = pwdata[CTRL_3W];
          fast_d = pwdata[CTRL_FAST];
          idx_d = pwdata[CTRL_IDX_LSB +: 7];
          wdata_d = pwdata[CTRL_WDATA_LSB +: 8];
          if (pwdata[CTRL_GO]) begin
            st_d = H_LEAD;
            csN_d = 1'b0;
            tmr_d = 5'(LEAD_CYC - 1);
            bits_d = 5'h00;
            // Command first: direction, index MSB first, then data.
            tx_d = {pwdata[CTRL_READ], pwdata[CTRL_IDX_LSB +: 7],
                    pwdata[CTRL_WDATA_LSB +: 8]};
          end
        end
      end
      H_LEAD, H_HIGH: begin
        if (tmr_q == 5'h00) begin
          st_d = H_LOW;
          sclk_d = 1'b0;
          tmr_d = half;
          dat_d = tx_q[15];
          tx_d = {tx_q[14:0], 1'b1};
          // In three-wire form the line is let go for the reply bits.
          oeN_d = tw_q && read_q && bits_q >= 5'd8;
        end
      end
      H_LOW: begin
        if (tmr_q == 5'h00) begin
          sclk_d = 1'b1;
          tmr_d = half;
          rx_d = {rx_q[14:0], rxBit};
          bits_d = bits_q + 5'h01;
          st_d = (bits_q == lastBit) ? H_TRAIL : H_HIGH;
        end
      end
      H_TRAIL: begin
        if (tmr_q == 5'h00) begin
          st_d = H_IDLE;
          csN_d = 1'b1;
          oeN_d = 1'b1;
          done = 1'b1;
          rxData_d = burst_q ? {rx_q[7:0], rx_q[15:8]}
                             : {8'h00, rx_q[7:0]};
        end
      end
      default: st_d = H_IDLE;
    endcase
    if (wrAcc && paddr == OFS_IRQ_MASK) begin
      mask_d = pwdata[IRQ_DONE];
    end
    // A completion in the clearing cycle survives the clear.
    stat_d = (stat_q && !(wrAcc && paddr == OFS_IRQ_STAT &&
              pwdata[IRQ_DONE])) || done;
    irq_d = stat_d && mask_d;
    if (setup) begin
      pslverr_d = !mapped;
      case (paddr)
        OFS_CTRL: prdata_d = {8'h00, wdata_q, 1'b0, idx_q, 3'h0, fast_q,
                              tw_q, burst_q, read_q, 1'b0};
        OFS_STATUS: prdata_d = {31'h0, st_q != H_IDLE};
        OFS_RXDATA: prdata_d = {16'h0000, rxData_q};
        OFS_IRQ_STAT: prdata_d = {31'h0, stat_q};
        OFS_IRQ_MASK: prdata_d = {31'h0, mask_q};
        default: prdata_d = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      st_q <= H_IDLE;
      tmr_q <= 5'h00;
      bits_q <= 5'h00;
      tx_q <= 16'h0000;
      rx_q <= 16'h0000;
      rxData_q <= 16'h0000;
      read_q <= 1'b0;
      burst_q <= 1'b0;
      tw_q <= 1'b0;
      fast_q <= 1'b0;
      idx_q <= 7'h00;
      wdata_q <= 8'h00;
      sclk_q <= 1'b1;
      csN_q <= 1'b1;
      dat_q <= 1'b1;
      oeN_q <= 1'b1;
      stat_q <= 1'b0;
      mask_q <= 1'b0;
      irq_q <= 1'b0;
      prdata_q <= REG_RESET;
      pslverr_q <= 1'b0;
    end else begin
      st_q <= st_d;
      tmr_q <= tmr_d;
      bits_q <= bits_d;
      tx_q <= tx_d;
      rx_q <= rx_d;
      rxData_q <= rxData_d;
      read_q <= read_d;
      burst_q <= burst_d;
      tw_q <= tw_d;
      fast_q <= fast_d;
      idx_q <= idx_d;
      wdata_q <= wdata_d;
      sclk_q <= sclk_d;
      csN_q <= csN_d;
      dat_q <= dat_d;
      oeN_q <= oeN_d;
      stat_q <= stat_d;
      mask_q <= mask_d;
      irq_q <= irq_d;
      prdata_q <= prdata_d;
      pslverr_q <= pslverr_d;
    end
  end

  // The slave never inserts wait states.
  assign pready = 1'b1;
  assign prdata = prdata_q;
  assign pslverr = pslverr_q;
  assign irq = irq_q;
  assign spi.sclk = sclk_q;
  assign spi.chip_select_n = csN_q;
  assign spi.hostDat = dat_q;
  assign spi.hostDatOeN = oeN_q;

endmodule // asp_host

//--- test/asp_asserts.sv
// Concurrent checks on the serial link between host and sensor ends.
`timescale 1ns/1ps
module asp_asserts import asp_pkg::*; (
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Link signals
  input wire logic sclk,
  input wire logic chip_select_n,
  input wire logic hostDatOeN,
  input wire logic devSdat,
  input wire logic devSdatOeN,
  input wire logic devMiso,
  input wire logic devMisoOeN,
  input wire logic bidirectional_serial_data,
  input wire logic miso
);
  logic [4:0] riseCnt_q, riseCnt_d;
  logic [3:0] phCnt_q, phCnt_d;
  logic sclkOld_q;
  // ****************
  // Helper counters
  // ****************
  // Phase counter saturates so a long idle never wraps into a short phase.
  always_comb begin
    riseCnt_d = chip_select_n ? 5'h00 : riseCnt_q + {4'h0, sclk & ~sclkOld_q};
    phCnt_d = (sclk != sclkOld_q) ? 4'h0 :
              phCnt_q + {3'h0, phCnt_q != 4'hF};
  end
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      riseCnt_q <= 5'h00;
      phCnt_q <= 4'hF;
      sclkOld_q <= 1'b1;
    end else begin
      riseCnt_q <= riseCnt_d;
      phCnt_q <= phCnt_d;
      sclkOld_q <= sclk;
    end
  end
  // ****************
  // Properties
  // ****************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  sclk_idle_a: assert property (chip_select_n |-> sclk)
    else $error("serial clock low outside a frame");
  lead_time_a: assert property ($fell(chip_select_n) |-> sclk [*8])
    else $error("serial clock fell too soon after select");
  phase_len_a: assert property ($changed(sclk) |-> phCnt_q >= HALF_CYC - 1)
    else $error("serial clock phase too short");
  tail_time_a: assert property ($rose(chip_select_n) |-> sclk && phCnt_q >= HALF_CYC - 1)
    else $error("select rose too soon after last clock rise");
  frame_len_a: assert property ($rose(chip_select_n) |-> riseCnt_q == 5'd16 || riseCnt_q == 5'd24)
    else $error("frame clock count wrong");
  one_driver_a: assert property (!(!hostDatOeN && !devSdatOeN))
    else $error("both ends drive the shared line");
  bidirectional_serial_data_hold_a: assert property ($rose(sclk) && !chip_select_n |=> $stable(bidirectional_serial_data) [*3])
    else $error("shared data moved while clock high");
  miso_hold_a: assert property ($rose(sclk) && !devMisoOeN |=> $stable(miso) [*3])
    else $error("device output moved while clock high");
  dev_change_a: assert property ((!devSdatOeN && $changed(devSdat)) ||
    (!devMisoOeN && $changed(devMiso)) |-> !sclk)
    else $error("device changed data while clock high");
  dev_release_a: assert property (chip_select_n [*6] |-> devSdatOeN && devMisoOeN)
    else $error("device still drives after frame end");
  cover property ($rose(chip_select_n) && riseCnt_q == 5'd24);
  cover property ($rose(chip_select_n) && riseCnt_q == 5'd16);
  cover property (!devSdatOeN);
  cover property (!devMisoOeN);
endmodule // asp_asserts

//--- test/angle_sensor_spi_slave_tb_top.sv
// Testbench joining the serial host and sensor ends, with the host driven over APB.
`timescale 1ns/1ps
module angle_sensor_spi_slave_tb_top import asp_pkg::*;;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata;
  logic pready, pslverr, irq, writeStrobe;
  logic [ANGLE_W-1:0] angle = '0;
  logic fieldLoss = 1'b0, threeWireSelect = 1'b0;
  logic [6:0] writeIndex, wIdx;
  logic [7:0] writeData, wDat, hi, lo;
  logic [7:0] ofs[5] = '{OFS_CTRL, OFS_STATUS, OFS_RXDATA, OFS_IRQ_STAT,
                         OFS_IRQ_MASK};
  logic [32:0] rdQ[$], mskQ[$];
  logic [14:0] wrQ[$];
  int errTotal = 0, nCompared = 0;
  always #12.5 clk = ~clk;
  asp_spi_if spiBus();
  asp_device asp_device_inst(.clk, .reset_n, .spi(spiBus), .angle,
    .fieldLoss, .threeWireSelect, .writeStrobe, .writeIndex, .writeData);
  asp_host asp_host_inst(.clk, .reset_n, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .irq, .spi(spiBus));
  asp_asserts asp_asserts_inst(.clk, .reset_n, .sclk(spiBus.sclk),
    .chip_select_n(spiBus.chip_select_n), .hostDatOeN(spiBus.hostDatOeN),
    .devSdat(spiBus.devSdat), .devSdatOeN(spiBus.devSdatOeN),
    .devMiso(spiBus.devMiso), .devMisoOeN(spiBus.devMisoOeN),
    .bidirectional_serial_data(spiBus.bidirectional_serial_data), .miso(spiBus.miso));
  // ****************
  // Compare and bus tasks
  // ****************
  task automatic chk_val(string nm, logic [32:0] e, logic [32:0] g,
                         logic [32:0] m);
    nCompared++;
    if (((g ^ e) & m) !== 33'h0) begin
      errTotal++;
      $display("wrong value %s expected %0h seen %0h", nm, e & m, g & m);
    end
  endtask
  task automatic chk_irq(logic e);
    nCompared++;
    if (irq !== e) begin
      errTotal++;
      $display("wrong value irq expected %0b seen %0b", e, irq);
    end
  endtask
  task automatic apb(logic wr, logic [7:0] a, logic [31:0] d,
                     logic [32:0] e = 33'h0, logic [32:0] m = '1);
    @(posedge clk);
    if (!wr) begin
      rdQ.push_back(e);
      mskQ.push_back(m);
    end
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) begin
      @(posedge clk);
    end
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Waits for the frame to open and close; a hang is left to the watchdog.
  task automatic wait_done();
    while (spiBus.chip_select_n !== 1'b0) begin
      @(posedge clk);
    end
    while (spiBus.chip_select_n !== 1'b1) begin
      @(posedge clk);
    end
    repeat (4) @(posedge clk);
  endtask
  function automatic logic [31:0] ctl(logic rd, logic bu, logic [6:0] ix,
                                      logic [7:0] dt);
    return {8'h00, dt, 1'b0, ix, 4'h0, threeWireSelect, bu, rd, 1'b1};
  endfunction
  // ****************
  // Result watcher
  // ****************
  always @(posedge clk) begin
    if (psel && penable && pready && !pwrite) begin
      if (rdQ.size() == 0) chk_val("read note", 33'h0, 33'h1, '1);
      else chk_val("apb read", rdQ.pop_front(), {pslverr, prdata},
                   mskQ.pop_front());
    end
    if (writeStrobe === 1'b1) begin
      if (wrQ.size() == 0) chk_val("write note", 33'h0, 33'h1, '1);
      else chk_val("write", 33'(wrQ.pop_front()),
                   33'({writeIndex, writeData}), '1);
    end
  end
  task automatic wrap_up();
    $display("compared %0d mismatches %0d", nCompared, errTotal);
    if (errTotal == 0 && nCompared > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  initial begin
    #1000000;
    errTotal++;
    wrap_up();
  end
  // ****************
  // Main sequence
  // ****************
  initial begin
    void'($urandom(32'h1E50D257));
    repeat (2) @(posedge clk);
    reset_n <= 1'b1;
    foreach (ofs[i]) apb(1'b0, ofs[i], 32'h0, 33'h0);
    apb(1'b0, 8'h20, 32'h0, {1'b1, 32'h0});
    apb(1'b1, OFS_IRQ_MASK, 32'h1);
    for (int tw = 0; tw < 2; tw++) begin
      threeWireSelect <= tw[0];
      angle <= 14'($urandom);
      fieldLoss <= 1'($urandom);
      @(posedge clk);
      hi = angle[13:6];
      lo = {angle[5:0], fieldLoss, 1'b0};
      apb(1'b1, OFS_CTRL, ctl(1'b1, 1'b0, IDX_ANGLE_HI, 8'h00));
      wait_done();
      chk_irq(1'b1);
      apb(1'b0, OFS_RXDATA, 32'h0, {25'h0, hi}, 33'hFF);
      apb(1'b1, OFS_IRQ_STAT, 32'h1);
      repeat (2) @(posedge clk);
      chk_irq(1'b0);
      apb(1'b1, OFS_CTRL, ctl(1'b1, 1'b0, IDX_ANGLE_LO, 8'h00));
      wait_done();
      apb(1'b0, OFS_RXDATA, 32'h0, {25'h0, lo}, 33'hFF);
      apb(1'b1, OFS_CTRL, ctl(1'b1, 1'b1, IDX_ANGLE_HI, 8'h00));
      wait_done();
      apb(1'b0, OFS_RXDATA, 32'h0, {17'h0, lo, hi}, 33'hFFFF);
      apb(1'b1, OFS_CTRL, ctl(1'b1, 1'b0, 7'h10, 8'h00));
      wait_done();
      apb(1'b0, OFS_RXDATA, 32'h0, 33'h0, 33'hFF);
      wIdx = 7'($urandom);
      wDat = 8'($urandom);
      wrQ.push_back({wIdx, wDat});
      apb(1'b1, OFS_CTRL, ctl(1'b0, 1'b0, wIdx, wDat));
      wait_done();
    end
    // Masked done event, with an order written while busy that must be lost.
    apb(1'b1, OFS_IRQ_MASK, 32'h0);
    apb(1'b1, OFS_IRQ_STAT, 32'h1);
    apb(1'b1, OFS_CTRL, ctl(1'b1, 1'b0, IDX_ANGLE_HI, 8'h00));
    apb(1'b0, OFS_STATUS, 32'h0, 33'h1, 33'h1);
    apb(1'b1, OFS_CTRL, ctl(1'b0, 1'b0, 7'h05, 8'hA5));
    wait_done();
    chk_irq(1'b0);
    apb(1'b0, OFS_IRQ_STAT, 32'h0, 33'h1, '1);
    apb(1'b0, OFS_RXDATA, 32'h0, {25'h0, hi}, 33'hFF);
    repeat (10) @(posedge clk);
    chk_val("notes left", 33'h0, 33'(rdQ.size() + wrQ.size()), '1);
    wrap_up();
  end
endmodule // angle_sensor_spi_slave_tb_top
